// ### shared/dsadc_conv_if.sv
// Purpose: carrier between control registers and decimation sequencer
// Assumes: single clock domain
// Notes:   ctl side drives settings, seq side returns result events
interface dsadc_conv_if;
   logic                 run;
   logic                 frst;
   logic [5:0]           n_ratio;
   logic [15:0]          osr;
   logic [4:0]           ckdiv;
   logic                 done;
   logic [23:0]          sample;
   modport ctl (output run, output frst, output n_ratio, output osr, output ckdiv,
                input done, input sample);
   modport seq (input run, input frst, input n_ratio, input osr, input ckdiv,
                output done, output sample);
endinterface

// ### shared/dsadc_pkg.sv
// Purpose: constants and types for the delta-sigma converter control block
// Assumes: classic wishbone, 32-bit data, byte addresses = offset * 4
// Notes:   register indices kept as printed; byte address is four times the index
//
// Overview of operation
// - filter reset aborts result, holds decimator
// - no new conversion until reset bit clears
// - sleep stops converter, keeps amplifier and bandgap
// - power off overrides sleep and reset
// - oversample code 0..8 gives 32768 down to 128
// - reference pair: internal at zero, external at one
// - clock ratio code 000 gives 30, 010 gives 12
// - buffer bits enable buffer, disable bypass; enable only while converter powered (run or reset)
// - hold bit keeps latest result, drops later
// - hold keeps converter running, done flag frozen
// - done flag set by hardware, cleared by software
// - result rate is master clock over N times OSR
// - master clock is source or source/2/(div+1)
// - lowest bit of secondary register reads zero
// - result is 24-bit two's complement
// - stored result replaced each conversion unless held
package dsadc_pkg;
   localparam logic [7:0] DSADC_IDX_CTL0 = 8'h07;
   localparam logic [7:0] DSADC_IDX_CTL1 = 8'h08;
   localparam logic [7:0] DSADC_IDX_CKDIV = 8'h09;
   localparam logic [7:0] DSADC_IDX_RES_LO = 8'h0a;
   localparam logic [7:0] DSADC_IDX_RES_MID = 8'h0b;
   localparam logic [7:0] DSADC_IDX_RES_HI = 8'h0c;
   localparam logic [7:0] DSADC_CTL0_RST = 8'h20;
   localparam logic [7:0] DSADC_CTL1_RST = 8'h00;
   localparam logic [4:0] DSADC_CKDIV_RST = 5'h00;
   localparam logic [4:0] DSADC_CKDIV_BYPASS = 5'h1f;
   localparam int DSADC_B_FRST = 7;
   localparam int DSADC_B_SLEEP = 6;
   localparam int DSADC_B_POFF = 5;
   localparam int DSADC_B_VREF = 0;
   localparam int DSADC_B_NBUF = 4;
   localparam int DSADC_B_PBUF = 3;
   localparam int DSADC_B_HOLD = 2;
   localparam int DSADC_B_DONE = 1;
   localparam logic [2:0] DSADC_CR_30 = 3'h0;
   localparam logic [2:0] DSADC_CR_12 = 3'h2;
   localparam logic [5:0] DSADC_N_30 = 6'h1e;
   localparam logic [5:0] DSADC_N_12 = 6'h0c;
   localparam logic [3:0] DSADC_OSR_MAX_CODE = 4'h8;
   localparam logic [15:0] DSADC_OSR_BASE = 16'h8000;
   localparam int DSADC_RES_W = 24;
   typedef enum logic [1:0] {
      DSADC_OFF   = 2'b00,
      DSADC_SLEEP = 2'b01,
      DSADC_RESET = 2'b10,
      DSADC_RUN   = 2'b11
   } dsadc_mode_t;
endpackage

// ### src/dsadc_ctrl.sv
// Purpose: register file and mode control of the delta-sigma converter
// Assumes: wishbone classic slave, word addressed via adr_i[9:2]
// Notes:   analog controls leave as registered levels
//
// Local design decision: the Wishbone interface to the registers.
module dsadc_ctrl (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic        mod_bit_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             err_o,
   output logic             pwr_conv_o,
   output logic             pwr_bandgap_o,
   output logic             pwr_amp_o,
   output logic             filt_rst_o,
   output logic             ref_ext_o,
   output logic             nbuf_en_o,
   output logic             nbuf_bypass_o,
   output logic             pbuf_en_o,
   output logic             pbuf_bypass_o,
   output logic [2:0]       mode_o
);
   typedef struct packed {
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic [4:0]  ckdiv;
      logic [23:0] result;
      logic [31:0] dat;
      logic        ack;
      logic        err;
      logic [9:0]  ana;
      logic [2:0]  mode;
   } dsadc_ctl_t;
   dsadc_ctl_t s_q, s_d;
   dsadc_conv_if cv ();
   dsadc_pkg::dsadc_mode_t mode;
   logic req, wr, rd;
   logic [7:0] idx;

   function automatic logic [15:0] osr_of(input logic [3:0] code);
      // reserved codes fall back to the slowest setting
      if (code > dsadc_pkg::DSADC_OSR_MAX_CODE) osr_of = dsadc_pkg::DSADC_OSR_BASE;
      else osr_of = dsadc_pkg::DSADC_OSR_BASE >> code;
   endfunction

   function automatic logic [5:0] n_of(input logic [2:0] code);
      if (code == dsadc_pkg::DSADC_CR_12) n_of = dsadc_pkg::DSADC_N_12;
      else n_of = dsadc_pkg::DSADC_N_30;
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
      merge = en ? nw : old;
   endfunction

   assign req = cyc_i && stb_i && !s_q.ack && !s_q.err;
   assign idx = adr_i[9:2];
   assign wr = req && we_i;
   assign rd = req && !we_i;

   // power off wins over sleep, sleep over reset
   always_comb begin
      if (s_q.ctl0[dsadc_pkg::DSADC_B_POFF]) mode = dsadc_pkg::DSADC_OFF;
      else if (s_q.ctl0[dsadc_pkg::DSADC_B_SLEEP]) mode = dsadc_pkg::DSADC_SLEEP;
      else if (s_q.ctl0[dsadc_pkg::DSADC_B_FRST]) mode = dsadc_pkg::DSADC_RESET;
      else mode = dsadc_pkg::DSADC_RUN;
   end

   assign cv.run = (mode == dsadc_pkg::DSADC_RUN) || (mode == dsadc_pkg::DSADC_RESET);
   assign cv.frst = s_q.ctl0[dsadc_pkg::DSADC_B_FRST] || mode == dsadc_pkg::DSADC_SLEEP;
   assign cv.osr = osr_of(s_q.ctl0[4:1]);
   assign cv.n_ratio = n_of(s_q.ctl1[7:5]);
   assign cv.ckdiv = s_q.ckdiv;

   dsadc_decim u_decim (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .mod_bit_i (mod_bit_i),
      .cv        (cv)
   );

   always_comb begin
      logic hold;
      logic on;
      hold = s_q.ctl1[dsadc_pkg::DSADC_B_HOLD];
      on = !s_q.ctl0[dsadc_pkg::DSADC_B_POFF];
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.err = 1'b0;
      if (req) begin
         s_d.dat = 32'h00000000;
         case (idx)
            dsadc_pkg::DSADC_IDX_CTL0: begin
               s_d.ack = 1'b1;
               s_d.dat = {24'h000000, s_q.ctl0};
               if (wr) s_d.ctl0 = merge(s_q.ctl0, dat_i[7:0], sel_i[0]);
            end
            dsadc_pkg::DSADC_IDX_CTL1: begin
               s_d.ack = 1'b1;
               s_d.dat = {24'h000000, s_q.ctl1[7:1], 1'b0};
               if (wr && sel_i[0]) s_d.ctl1 = {dat_i[7:1], 1'b0};
            end
            dsadc_pkg::DSADC_IDX_CKDIV: begin
               s_d.ack = 1'b1;
               s_d.dat = {27'h0000000, s_q.ckdiv};
               if (wr && sel_i[0]) s_d.ckdiv = dat_i[4:0];
            end
            dsadc_pkg::DSADC_IDX_RES_LO: begin
               s_d.ack = 1'b1;
               s_d.dat = {24'h000000, s_q.result[7:0]};
            end
            dsadc_pkg::DSADC_IDX_RES_MID: begin
               s_d.ack = 1'b1;
               s_d.dat = {24'h000000, s_q.result[15:8]};
            end
            dsadc_pkg::DSADC_IDX_RES_HI: begin
               s_d.ack = 1'b1;
               s_d.dat = {24'h000000, s_q.result[23:16]};
            end
            default: begin
               s_d.err = 1'b1;
            end
         endcase
      end
      // hardware set beats a software clear in the same cycle
      if (cv.done && !hold && on) begin
         s_d.ctl1[dsadc_pkg::DSADC_B_DONE] = 1'b1;
         s_d.result = cv.sample;
      end
      s_d.mode = 3'(mode);
      s_d.ana[0] = on && mode == dsadc_pkg::DSADC_RUN || mode == dsadc_pkg::DSADC_RESET;
      s_d.ana[1] = on;
      s_d.ana[2] = on;
      s_d.ana[3] = s_q.ctl0[dsadc_pkg::DSADC_B_FRST] && on;
      s_d.ana[4] = s_q.ctl0[dsadc_pkg::DSADC_B_VREF];
      s_d.ana[5] = s_q.ctl1[dsadc_pkg::DSADC_B_NBUF] && s_d.ana[0];
      s_d.ana[6] = !s_q.ctl1[dsadc_pkg::DSADC_B_NBUF];
      s_d.ana[7] = s_q.ctl1[dsadc_pkg::DSADC_B_PBUF] && s_d.ana[0];
      s_d.ana[8] = !s_q.ctl1[dsadc_pkg::DSADC_B_PBUF];
      s_d.ana[9] = 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.ctl0 <= dsadc_pkg::DSADC_CTL0_RST;
         s_q.ctl1 <= dsadc_pkg::DSADC_CTL1_RST;
         s_q.ckdiv <= dsadc_pkg::DSADC_CKDIV_RST;
         s_q.mode <= 3'(dsadc_pkg::DSADC_OFF);
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o = s_q.dat;
   assign ack_o = s_q.ack;
   assign err_o = s_q.err;
   assign pwr_conv_o = s_q.ana[0];
   assign pwr_bandgap_o = s_q.ana[1];
   assign pwr_amp_o = s_q.ana[2];
   assign filt_rst_o = s_q.ana[3];
   assign ref_ext_o = s_q.ana[4];
   assign nbuf_en_o = s_q.ana[5];
   assign nbuf_bypass_o = s_q.ana[6];
   assign pbuf_en_o = s_q.ana[7];
   assign pbuf_bypass_o = s_q.ana[8];
   assign mode_o = s_q.mode;

   a_hold_freezes_result: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.ctl1[dsadc_pkg::DSADC_B_HOLD] |=> $stable(s_q.result))
      else $error("result changed while held");

   a_hold_freezes_done: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.ctl1[dsadc_pkg::DSADC_B_HOLD] && !(wr && idx == dsadc_pkg::DSADC_IDX_CTL1)
      |=> $stable(s_q.ctl1[dsadc_pkg::DSADC_B_DONE]))
      else $error("done flag moved while held");

   a_done_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      cv.done && !s_q.ctl1[dsadc_pkg::DSADC_B_HOLD] && !s_q.ctl0[dsadc_pkg::DSADC_B_POFF]
      |=> s_q.ctl1[dsadc_pkg::DSADC_B_DONE] && s_q.result == $past(cv.sample))
      else $error("completion not recorded");

   a_frst_no_result: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.ctl0[dsadc_pkg::DSADC_B_FRST] |-> ##2 !cv.done)
      else $error("result during filter reset");

   a_poff_all_off: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.ctl0[dsadc_pkg::DSADC_B_POFF] |=> !pwr_conv_o && !pwr_bandgap_o && !pwr_amp_o)
      else $error("power off not applied");

   a_sleep_keeps_amp: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.ctl0[dsadc_pkg::DSADC_B_POFF] && s_q.ctl0[dsadc_pkg::DSADC_B_SLEEP]
      |=> !pwr_conv_o && pwr_amp_o && pwr_bandgap_o)
      else $error("sleep power state wrong");

   a_lsb_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      rd && idx == dsadc_pkg::DSADC_IDX_CTL1 |=> ack_o && dat_o[0] == 1'b0)
      else $error("unused bit read as one");

   a_ref_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 ref_ext_o == $past(s_q.ctl0[dsadc_pkg::DSADC_B_VREF]))
      else $error("reference select not followed");

   a_buf_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
      nbuf_en_o |-> !nbuf_bypass_o)
      else $error("buffer and bypass both on");
endmodule

// ### src/dsadc_decim.sv
// Purpose: master clock divider and decimation result timer
// Assumes: source clock is clk; master clock is an enable derived here
// Notes:   sample value comes from modulator bits accumulated over one frame
module dsadc_decim (
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   input  wire logic     mod_bit_i,
   dsadc_conv_if.seq     cv
);
   typedef struct packed {
      logic [5:0]  pre;
      logic        mclk_en;
      logic [5:0]  ncnt;
      logic [15:0] ocnt;
      logic [23:0] acc;
      logic        done;
      logic [23:0] sample;
   } dsadc_dec_t;
   dsadc_dec_t s_q, s_d;
   logic [5:0] pre_lim;

   // bypass code runs at source rate, else divide by 2*(div+1)
   assign pre_lim = (cv.ckdiv == dsadc_pkg::DSADC_CKDIV_BYPASS) ? 6'h00
                  : 6'({cv.ckdiv, 1'b1});

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.mclk_en = 1'b0;
      if (s_q.pre >= pre_lim) begin
         s_d.pre = 6'h00;
         s_d.mclk_en = 1'b1;
      end else begin
         s_d.pre = s_q.pre + 6'h01;
      end
      if (!cv.run || cv.frst) begin
         s_d.ncnt = 6'h00;
         s_d.ocnt = 16'h0000;
         s_d.acc = 24'h000000;
      end else if (s_q.mclk_en) begin
         if (s_q.ncnt >= cv.n_ratio - 6'h01) begin
            s_d.ncnt = 6'h00;
            // modulator bit taken once per modulator clock
            s_d.acc = s_q.acc + (mod_bit_i ? 24'h000001 : 24'hffffff);
            if (s_q.ocnt >= cv.osr - 16'h0001) begin
               s_d.ocnt = 16'h0000;
               s_d.acc = 24'h000000;
               s_d.done = 1'b1;
               s_d.sample = s_q.acc;
            end else begin
               s_d.ocnt = s_q.ocnt + 16'h0001;
            end
         end else begin
            s_d.ncnt = s_q.ncnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) s_q <= '0;
      else s_q <= s_d;
   end

   assign cv.done = s_q.done;
   assign cv.sample = s_q.sample;
endmodule

// ### verification/dsadc_mod_model.sv
// Purpose: modulator bit stream standing in for the analog front end
// Assumes: one modulator bit per clock, no framing
// Notes:   pattern changes every cycle so a stuck sampler shows up
module dsadc_mod_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   output logic      bit_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sh_q;
   always @(posedge clk_i) begin
      if (rst_i) sh_q <= 16'hace1;
      else sh_q <= {sh_q[14:0], sh_q[15] ^ sh_q[13] ^ sh_q[12] ^ sh_q[10]};
   end
   assign bit_o = sh_q[0];
endmodule

// ### verification/test_delta_sigma_adc_control.sv
// Purpose: self-checking bench of the converter control block
// Assumes: div 31, ratio 010, osr code 8 gives 1536 cycles a result
// Notes:   wait windows keep margin around the result period
module test_delta_sigma_adc_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, mod_bit;
   logic [31:0] adr = 32'h0, dat_i = 32'h0, dat_o;
   logic [3:0]  sel = 4'h0;
   logic        ack_o, err_o, pconv, pbg, pamp, frst, rext, nbe, nbb, pbe, pbb;
   logic [2:0]  mode;
   int          failures = 0, cmp_count = 0, cycles = 0, i, s;
   logic [31:0] rs = 32'h571befd9;
   logic [7:0]  rd, v;
   logic        er;
   logic [23:0] res0, res1;
   dsadc_mod_model u_mod (.clk_i(clk_i), .rst_i(rst_i), .bit_o(mod_bit));
   dsadc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat_i), .mod_bit_i(mod_bit), .dat_o(dat_o),
      .ack_o(ack_o), .err_o(err_o), .pwr_conv_o(pconv), .pwr_bandgap_o(pbg),
      .pwr_amp_o(pamp), .filt_rst_o(frst), .ref_ext_o(rext), .nbuf_en_o(nbe),
      .nbuf_bypass_o(nbb), .pbuf_en_o(pbe), .pbuf_bypass_o(pbb), .mode_o(mode));
   always #25 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // request held until the edge that samples the answer
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {22'h0, idx, 2'b00};
      dat_i <= {24'h0, wd};
      sel <= 4'h1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      rd = dat_o[7:0];
      er = err_o;
      chk("bus answer", 32'h1, {31'h0, n < 20});
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string nm);
      wb(1'b0, idx, 8'h00);
      chk(nm, {24'h0, e}, {24'h0, rd});
   endtask
   task automatic rdres(output logic [23:0] r);
      wb(1'b0, 8'h0a, 8'h00);
      r[7:0] = rd;
      wb(1'b0, 8'h0b, 8'h00);
      r[15:8] = rd;
      wb(1'b0, 8'h0c, 8'h00);
      r[23:16] = rd;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      wt(20);
      rst_i <= 1'b0;
      wt(2);
      chk("reset mode", 32'h0, {29'h0, mode});
      chk("reset power", 32'h0, {29'h0, pconv, pbg, pamp});
      chk("reset bypass", 32'h3, {30'h0, nbb, pbb});
      rdc(8'h07, 8'h20, "ctl0 reset");
      rdc(8'h08, 8'h00, "ctl1 reset");
      wb(1'b0, 8'h3f, 8'h00);
      chk("unmapped err", 32'h1, {31'h0, er === 1'b1 && rd === 8'h00});
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         rs = lfsr(rs);
         v = {i[2:0], rs[4:0]};
         wb(1'b1, 8'h07, v);
         rdc(8'h07, v, "ctl0 readback");
         chk("mode", {29'h0, v[5] ? 3'h0 : v[6] ? 3'h1 : v[7] ? 3'h2 : 3'h3}, {29'h0, mode});
         chk("ref select", {31'h0, v[0]}, {31'h0, rext});
         chk("conv power", {31'h0, !v[5] && !v[6]}, {31'h0, pconv});
         chk("amp power", {31'h0, !v[5]}, {31'h0, pamp});
         if (!v[5] && !v[6]) chk("filter reset", {31'h0, v[7]}, {31'h0, frst});
      end
      $display("test modes done");
      // buffers only switch while the converter runs; slowest rate keeps done clear
      wb(1'b1, 8'h07, 8'h00);
      for (i = 0; i < 8; i++) begin
         rs = lfsr(rs);
         v = rs[7:0] & 8'hfd;
         wb(1'b1, 8'h08, v);
         rdc(8'h08, v & 8'hfc, "ctl1 readback");
         chk("buffers", {28'h0, v[4], !v[4], v[3], !v[3]}, {28'h0, nbe, nbb, pbe, pbb});
      end
      $display("test buffers done");
      // start order: power on with reset raised, then release it
      wb(1'b1, 8'h09, 8'h1f);
      wb(1'b1, 8'h08, 8'h40);
      wb(1'b1, 8'h07, 8'h90);
      wt(3000);
      rdc(8'h08, 8'h40, "done during reset");
      wb(1'b1, 8'h07, 8'h10);
      wt(1400);
      rdc(8'h08, 8'h40, "done early");
      wt(250);
      rdc(8'h08, 8'h42, "done set");
      $display("test period done");
      wb(1'b1, 8'h08, 8'h44);
      rdres(res0);
      s = int'(signed'(res0));
      chk("result range", 32'h1, {31'h0, s >= -1536 && s <= 1536});
      wt(1700);
      rdc(8'h08, 8'h44, "done frozen");
      rdres(res1);
      chk("held result", {8'h0, res0}, {8'h0, res1});
      wb(1'b1, 8'h08, 8'h40);
      wt(1700);
      rdc(8'h08, 8'h42, "done after hold");
      $display("test hold done");
      wb(1'b1, 8'h08, 8'h40);
      wb(1'b1, 8'h07, 8'h50);
      wt(1700);
      rdc(8'h08, 8'h40, "done in sleep");
      wb(1'b1, 8'h07, 8'h10);
      wt(800);
      wb(1'b1, 8'h07, 8'h90);
      wb(1'b1, 8'h07, 8'h10);
      wt(1400);
      rdc(8'h08, 8'h40, "done after abort");
      wt(250);
      rdc(8'h08, 8'h42, "done restarted");
      wb(1'b1, 8'h07, 8'h30);
      $display("test abort done");
      end_sim();
   end
endmodule
